// ===== rtl/cpurm_regmodel.sv
// Programmer-visible register model with AXI4-Lite access and execute port
`timescale 1ns/100ps
`include "cpurm_cfg.svh"
// Overview of operation
// - Eight data plus eight address 32-bit registers
// - 16-bit status word, PC, three stack pointers
// - Two 3-bit alternate function code registers
// - 32-bit cache address and control registers
// - Data registers: bit, field, byte, long, quad
// - Address registers take word and long only
// - Any of sixteen registers serves as index
// - Three-bit interrupt priority mask gates requests
// - Five condition flags updated by execution
// - Two trace bits, supervisor and master bits
// - Trace-every bit traps after each instruction
// - Flow-trace bit traps after flow changes only
// - Vector base locates the exception table
// - Decode eighteen addressing modes, nine groups
// - Indirect modes post-increment and pre-decrement; address seven is left unchanged
// - PC-relative displacement and index forms
// - Indexed forms: 8-bit and base displacement
// - Index register sized and scaled
// - Loop decrement branch tests, decrements, branches
// - Dual bound check traps outside limits
module cpurm_regmodel (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   input wire logic [2:0] irq_level_i,
   output logic irq_accept_o,
   output logic [31:0] vector_addr_o,
   output logic trap_o,
   input wire logic [`CPURM_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`CPURM_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import cpurm_pkg::*;

   // Register storage
   logic [31:0] data_regs [0:7];
   logic [31:0] addr_regs [0:6];
   logic [31:0] usp_q, isp_q, master_stack_ptr_q;
   logic [15:0] processor_state_word_q;
   logic [31:0] pc_q, vector_table_base_q, caddr_q, cctrl_q, ea_q;
   logic [2:0] sfc_q, dfc_q;
   logic [3:0] stat_q;
   logic [31:0] arg_q;
   logic [31:0] ctrl_q;
   cpurm_state_t state_q;
   // Captured write beat
   logic [`CPURM_ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   // Register window decode, shared by both bus channels
   function automatic logic in_gpr(input logic [`CPURM_ADDR_W-1:0] a);
      in_gpr = (a[7:6] == 2'b01);
   endfunction : in_gpr
   // Control fields
   wire cpurm_op_t cmd = cpurm_op_t'(ctrl_q[`CPURM_CMD_LO +: `CPURM_CMD_W]);
   wire [3:0] ra = ctrl_q[7:4];
   wire [3:0] rx = ctrl_q[11:8];
   wire cpurm_ea_t ea_mode = cpurm_ea_t'(ctrl_q[16:12]);
   wire cpurm_size_t op_size = cpurm_size_t'(ctrl_q[18:17]);
   wire idx_long = ctrl_q[19];
   wire [1:0] idx_scale = ctrl_q[21:20];
   wire [3:0] cond_sel = ctrl_q[25:22];
   wire bitfield_w = ctrl_q[26];
   wire sup = processor_state_word_q[`CPURM_PSW_S];
   wire mst = processor_state_word_q[`CPURM_PSW_M];
   // Address seven follows the operating state
   wire [31:0] a7_view = !sup ? usp_q : (mst ? master_stack_ptr_q : isp_q);
   // Sixteen-entry register view for reads and index selection
   wire [31:0] gpr_view [0:15];
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_view
         assign gpr_view[gi] = data_regs[gi];
         if (gi < 7) begin : g_a
            assign gpr_view[gi+8] = addr_regs[gi];
         end else begin : g_a7
            assign gpr_view[15] = a7_view;
         end
      end
   endgenerate
   wire [31:0] idx_val = gpr_view[rx];
   wire [31:0] reg_a = gpr_view[ra];

   // Effective address unit
   logic [31:0] ea_val, an_new;
   logic an_wr;
   cpurm_ea_unit u_ea (
      .mode_i(ea_mode),
      .base_i(reg_a),
      .pc_i(pc_q),
      .index_i(idx_val),
      .idx_long_i(idx_long),
      .scale_i(idx_scale),
      .disp_i(arg_q),
      .outer_i(caddr_q),
      .mem_i(arg_q),
      .size_i(op_size),
      .ea_o(ea_val),
      .an_new_o(an_new),
      .an_wr_o(an_wr)
   );

   // Condition evaluation from the flags
   wire fc = processor_state_word_q[`CPURM_PSW_C];
   wire fv = processor_state_word_q[`CPURM_PSW_V];
   wire fz = processor_state_word_q[`CPURM_PSW_Z];
   wire fn = processor_state_word_q[`CPURM_PSW_N];
   logic cond_true;
   always_comb begin
      case (cond_sel)
         4'h0: cond_true = 1'b1;
         4'h1: cond_true = 1'b0;
         4'h2: cond_true = !fc && !fz;
         4'h3: cond_true = fc || fz;
         4'h4: cond_true = !fc;
         4'h5: cond_true = fc;
         4'h6: cond_true = !fz;
         4'h7: cond_true = fz;
         4'h8: cond_true = !fv;
         4'h9: cond_true = fv;
         4'hA: cond_true = !fn;
         4'hB: cond_true = fn;
         4'hC: cond_true = fn == fv;
         4'hD: cond_true = fn != fv;
         4'hE: cond_true = !fz && (fn == fv);
         default: cond_true = fz || (fn != fv);
      endcase
   end

   // Loop counter on the low word of the selected data register
   wire [15:0] cnt_dec = data_regs[ra[2:0]][15:0] - 16'h0001;
   wire loop_branch = !cond_true && (cnt_dec != 16'hFFFF);
   // Bounds: lower in caddr, upper in arg, signed long compare
   wire signed [31:0] bnd_v = $signed(reg_a);
   wire bound_out = (bnd_v < $signed(caddr_q)) || (bnd_v > $signed(arg_q));
   // Flag results of a general execute step; low 32 bits are the result
   wire [32:0] exec_sum = {1'b0, reg_a} + {1'b0, arg_q};
   wire exec_v = (reg_a[31] == arg_q[31]) && (exec_sum[31] != reg_a[31]);

   // Bus-side write decode
   wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   wire [31:0] wr_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   wire wr_psw = wr_go && aw_addr_q == `CPURM_OFF_PSW;
   wire [15:0] psw_wval = (w_data_q[15:0] & wr_mask[15:0]) |
                          (processor_state_word_q & ~wr_mask[15:0]);
   // Upper byte held unless supervisor
   wire psw_upper_blocked = !sup && (psw_wval[15:8] != processor_state_word_q[15:8]);
   wire [15:0] psw_accept = psw_upper_blocked ?
        {processor_state_word_q[15:8], psw_wval[7:0]} : psw_wval;
   wire wr_known = aw_addr_q <= `CPURM_OFF_EA || in_gpr(aw_addr_q);
   // Address registers take word or long widths only
   wire gpr_wr_ok = !aw_addr_q[5] ||
        (w_strb_q == 4'hF) || (w_strb_q == 4'h3) || (w_strb_q == 4'hC);

   // Write address and data channel capture
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_addr_q <= '0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else if (clk_en_i) begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_known && gpr_wr_ok) ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // Read channel
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h00000000;
      if (in_gpr(s_axi_araddr)) rd_mux = gpr_view[s_axi_araddr[5:2]];
      else case (s_axi_araddr)
         `CPURM_OFF_CTRL: rd_mux = ctrl_q;
         `CPURM_OFF_STATUS: rd_mux = {26'h0, state_q, stat_q};
         `CPURM_OFF_PSW: rd_mux = {16'h0000, processor_state_word_q};
         `CPURM_OFF_PC: rd_mux = pc_q;
         `CPURM_OFF_VBR: rd_mux = vector_table_base_q;
         `CPURM_OFF_SFC: rd_mux = {29'h0, sfc_q};
         `CPURM_OFF_DFC: rd_mux = {29'h0, dfc_q};
         `CPURM_OFF_CADDR: rd_mux = caddr_q;
         `CPURM_OFF_CCTRL: rd_mux = cctrl_q;
         `CPURM_OFF_USP: rd_mux = usp_q;
         `CPURM_OFF_ISP: rd_mux = isp_q;
         `CPURM_OFF_MSP: rd_mux = master_stack_ptr_q;
         `CPURM_OFF_EA: rd_mux = ea_q;
         default: rd_mux = 32'h00000000;
      endcase
   end
   wire rd_known = in_gpr(s_axi_araddr) || s_axi_araddr <= `CPURM_OFF_EA;
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end else if (clk_en_i) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_known ? 2'b00 : 2'b10;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Execute sequencer: a command written to control runs for one step
   wire start = wr_go && aw_addr_q == `CPURM_OFF_CTRL;
   wire is_flow = (cmd == CPURM_OP_FLOW) || (cmd == CPURM_OP_LOOP && loop_branch);
   wire trace_hit = processor_state_word_q[`CPURM_PSW_T0] ||
                    (processor_state_word_q[`CPURM_PSW_T1] && is_flow);
   wire bound_hit = (cmd == CPURM_OP_BOUND) && bound_out;
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state_q <= CPURM_ST_IDLE;
         ctrl_q <= 32'h00000000;
         stat_q <= 4'h0;
         trap_o <= 1'b0;
         vector_addr_o <= 32'h00000000;
      end else if (clk_en_i) begin
         trap_o <= 1'b0;
         case (state_q)
            CPURM_ST_IDLE: begin
               if (start) begin
                  ctrl_q <= (w_data_q & wr_mask) | (ctrl_q & ~wr_mask);
                  state_q <= CPURM_ST_EXEC;
               end
            end
            CPURM_ST_EXEC: begin
               stat_q[`CPURM_ST_TRACE] <= trace_hit;
               stat_q[`CPURM_ST_BOUND] <= bound_hit;
               stat_q[`CPURM_ST_TAKEN] <= (cmd == CPURM_OP_LOOP) && loop_branch;
               stat_q[`CPURM_ST_PRIV] <= 1'b0;
               if (bound_hit || trace_hit) begin
                  trap_o <= 1'b1;
                  // Vector fetch address is base plus vector number times four
                  vector_addr_o <= vector_table_base_q +
                       {22'h0, (bound_hit ? 8'h06 : 8'h09), 2'b00};
               end
               state_q <= CPURM_ST_DONE;
            end
            CPURM_ST_DONE: state_q <= CPURM_ST_IDLE;
            default: state_q <= CPURM_ST_IDLE;
         endcase
         if (wr_psw && psw_upper_blocked) begin
            stat_q[`CPURM_ST_PRIV] <= 1'b1;
            trap_o <= 1'b1;
            vector_addr_o <= vector_table_base_q + 32'h00000020;
         end
      end
   end

   // Architectural register updates
   wire exec_step = clk_en_i && state_q == CPURM_ST_EXEC;
   wire wr_bit = cmd == CPURM_OP_EXEC && op_size == CPURM_SZ_BYTE && bitfield_w;
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         processor_state_word_q <= `CPURM_PSW_RST;
         pc_q <= 32'h00000000;
         vector_table_base_q <= 32'h00000000;
         sfc_q <= 3'h0;
         dfc_q <= 3'h0;
         caddr_q <= 32'h00000000;
         cctrl_q <= 32'h00000000;
         usp_q <= 32'h00000000;
         isp_q <= 32'h00000000;
         master_stack_ptr_q <= 32'h00000000;
         ea_q <= 32'h00000000;
         arg_q <= 32'h00000000;
         for (int i = 0; i < 8; i++) data_regs[i] <= 32'h00000000;
         for (int i = 0; i < 7; i++) addr_regs[i] <= 32'h00000000;
      end else if (clk_en_i) begin
         if (wr_go) begin
            case (aw_addr_q)
               `CPURM_OFF_PSW: processor_state_word_q <= psw_accept & `CPURM_PSW_MASK;
               `CPURM_OFF_PC: pc_q <= w_data_q;
               `CPURM_OFF_VBR: vector_table_base_q <= w_data_q;
               `CPURM_OFF_SFC: sfc_q <= w_data_q[2:0];
               `CPURM_OFF_DFC: dfc_q <= w_data_q[2:0];
               `CPURM_OFF_CADDR: caddr_q <= w_data_q;
               `CPURM_OFF_CCTRL: cctrl_q <= w_data_q;
               `CPURM_OFF_USP: usp_q <= w_data_q;
               `CPURM_OFF_ISP: isp_q <= w_data_q;
               `CPURM_OFF_MSP: master_stack_ptr_q <= w_data_q;
               `CPURM_OFF_EA: arg_q <= w_data_q;
               default: ;
            endcase
            if (in_gpr(aw_addr_q) && gpr_wr_ok) begin
               if (aw_addr_q[5] == 1'b0)
                  data_regs[aw_addr_q[4:2]] <= (w_data_q & wr_mask) |
                       (data_regs[aw_addr_q[4:2]] & ~wr_mask);
               else if (aw_addr_q[4:2] != 3'd7)
                  addr_regs[aw_addr_q[4:2]] <= w_data_q;
               else if (!sup) usp_q <= w_data_q;
               else if (mst) master_stack_ptr_q <= w_data_q;
               else isp_q <= w_data_q;
            end
         end
         if (exec_step) begin
            ea_q <= ea_val;
            if (an_wr && ra[3] && ra[2:0] != 3'd7) addr_regs[ra[2:0]] <= an_new;
            if (cmd == CPURM_OP_LOOP && !cond_true) begin
               data_regs[ra[2:0]][15:0] <= cnt_dec;
               if (loop_branch) pc_q <= pc_q + arg_q;
            end
            if (cmd == CPURM_OP_EXEC) begin
               // Quad result spans a register pair; bit writes touch one bit
               if (wr_bit)
                  data_regs[ra[2:0]][arg_q[4:0]] <= 1'b1;
               else if (op_size == CPURM_SZ_QUAD)
                  data_regs[ra[2:0] ^ 3'd1] <= {31'h0, exec_sum[32]};
               processor_state_word_q[4:0] <= {exec_sum[32], exec_sum[31],
                    exec_sum[31:0] == 32'h0, exec_v, exec_sum[32]};
            end
            if (cmd == CPURM_OP_BOUND)
               processor_state_word_q[`CPURM_PSW_C] <= bound_out;
         end
      end
   end

   // Interrupt acceptance against the priority mask
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) irq_accept_o <= 1'b0;
      else if (clk_en_i) irq_accept_o <= (irq_level_i == 3'd7) ||
           (irq_level_i > processor_state_word_q[`CPURM_PSW_IPL_LO +: 3]);
   end
endmodule : cpurm_regmodel

// ===== rtl/cpurm_cfg.svh
// Constants for the programmer register model
`ifndef CPURM_CFG_SVH
`define CPURM_CFG_SVH
`define CPURM_ADDR_W 8
// Register offsets on the AXI4-Lite slave
`define CPURM_OFF_CTRL 8'h00
`define CPURM_OFF_STATUS 8'h04
`define CPURM_OFF_PSW 8'h08
`define CPURM_OFF_PC 8'h0C
`define CPURM_OFF_VBR 8'h10
`define CPURM_OFF_SFC 8'h14
`define CPURM_OFF_DFC 8'h18
`define CPURM_OFF_CADDR 8'h1C
`define CPURM_OFF_CCTRL 8'h20
`define CPURM_OFF_USP 8'h24
`define CPURM_OFF_ISP 8'h28
`define CPURM_OFF_MSP 8'h2C
`define CPURM_OFF_EA 8'h30
`define CPURM_OFF_GPR 8'h40
// Status word field positions
`define CPURM_PSW_C 0
`define CPURM_PSW_V 1
`define CPURM_PSW_Z 2
`define CPURM_PSW_N 3
`define CPURM_PSW_X 4
`define CPURM_PSW_IPL_LO 8
`define CPURM_PSW_M 12
`define CPURM_PSW_S 13
`define CPURM_PSW_T0 14
`define CPURM_PSW_T1 15
`define CPURM_PSW_RST 16'h2700
`define CPURM_PSW_MASK 16'hF71F
// Control register command field
`define CPURM_CMD_LO 0
`define CPURM_CMD_W 3
// Status register bit positions
`define CPURM_ST_TRACE 0
`define CPURM_ST_PRIV 1
`define CPURM_ST_BOUND 2
`define CPURM_ST_TAKEN 3
`endif

// ===== rtl/cpurm_pkg.sv
// Types for the programmer register model
package cpurm_pkg;
   typedef enum logic [2:0] {
      CPURM_OP_NONE = 3'b000,
      CPURM_OP_LOOP = 3'b001,
      CPURM_OP_BOUND = 3'b010,
      CPURM_OP_FLOW = 3'b011,
      CPURM_OP_EA = 3'b100,
      CPURM_OP_WRPSW = 3'b101,
      CPURM_OP_EXEC = 3'b110
   } cpurm_op_t;
   typedef enum logic [1:0] {
      CPURM_SZ_BYTE = 2'b00,
      CPURM_SZ_WORD = 2'b01,
      CPURM_SZ_LONG = 2'b10,
      CPURM_SZ_QUAD = 2'b11
   } cpurm_size_t;
   typedef enum logic [4:0] {
      CPURM_EA_DREG = 5'd0, CPURM_EA_AREG = 5'd1, CPURM_EA_IND = 5'd2,
      CPURM_EA_POST = 5'd3, CPURM_EA_PRE = 5'd4, CPURM_EA_D16 = 5'd5,
      CPURM_EA_IDX8 = 5'd6, CPURM_EA_IDXBD = 5'd7, CPURM_EA_MPOST = 5'd8,
      CPURM_EA_MPRE = 5'd9, CPURM_EA_PCD16 = 5'd10, CPURM_EA_PCIDX8 = 5'd11,
      CPURM_EA_PCIDXBD = 5'd12, CPURM_EA_PCMPOST = 5'd13, CPURM_EA_PCMPRE = 5'd14,
      CPURM_EA_ABSW = 5'd15, CPURM_EA_ABSL = 5'd16, CPURM_EA_IMM = 5'd17
   } cpurm_ea_t;
   typedef enum logic [1:0] {
      CPURM_ST_IDLE = 2'b00,
      CPURM_ST_EXEC = 2'b01,
      CPURM_ST_DONE = 2'b10
   } cpurm_state_t;
endpackage : cpurm_pkg

// ===== rtl/cpurm_ea_unit.sv
// Effective address calculator for the eighteen addressing modes
`timescale 1ns/100ps
`include "cpurm_cfg.svh"
module cpurm_ea_unit (
   input wire cpurm_pkg::cpurm_ea_t mode_i,
   input wire logic [31:0] base_i,
   input wire logic [31:0] pc_i,
   input wire logic [31:0] index_i,
   input wire logic idx_long_i,
   input wire logic [1:0] scale_i,
   input wire logic [31:0] disp_i,
   input wire logic [31:0] outer_i,
   input wire logic [31:0] mem_i,
   input wire cpurm_pkg::cpurm_size_t size_i,
   output logic [31:0] ea_o,
   output logic [31:0] an_new_o,
   output logic an_wr_o
);
   import cpurm_pkg::*;
   logic [31:0] idx_ext;
   logic [31:0] idx_sc;
   logic [31:0] step;
   logic [31:0] d8;
   // Index sizing and scaling
   assign idx_ext = idx_long_i ? index_i : {{16{index_i[15]}}, index_i[15:0]};
   assign idx_sc = idx_ext << scale_i;
   assign d8 = {{24{disp_i[7]}}, disp_i[7:0]};
   assign step = (size_i == CPURM_SZ_BYTE) ? 32'h00000001 :
                 (size_i == CPURM_SZ_WORD) ? 32'h00000002 :
                 (size_i == CPURM_SZ_LONG) ? 32'h00000004 : 32'h00000008;
   // Mode decode into address and register update
   always_comb begin
      ea_o = 32'h00000000;
      an_new_o = base_i;
      an_wr_o = 1'b0;
      case (mode_i)
         CPURM_EA_DREG, CPURM_EA_AREG: ea_o = base_i;
         CPURM_EA_IND: ea_o = base_i;
         CPURM_EA_POST: begin
            ea_o = base_i;
            an_new_o = base_i + step;
            an_wr_o = 1'b1;
         end
         CPURM_EA_PRE: begin
            ea_o = base_i - step;
            an_new_o = base_i - step;
            an_wr_o = 1'b1;
         end
         CPURM_EA_D16: ea_o = base_i + {{16{disp_i[15]}}, disp_i[15:0]};
         CPURM_EA_IDX8: ea_o = base_i + d8 + idx_sc;
         CPURM_EA_IDXBD: ea_o = base_i + disp_i + idx_sc;
         CPURM_EA_MPOST: ea_o = mem_i + idx_sc + outer_i;
         CPURM_EA_MPRE: ea_o = mem_i + outer_i;
         CPURM_EA_PCD16: ea_o = pc_i + {{16{disp_i[15]}}, disp_i[15:0]};
         CPURM_EA_PCIDX8: ea_o = pc_i + d8 + idx_sc;
         CPURM_EA_PCIDXBD: ea_o = pc_i + disp_i + idx_sc;
         CPURM_EA_PCMPOST: ea_o = mem_i + idx_sc + outer_i;
         CPURM_EA_PCMPRE: ea_o = mem_i + outer_i;
         CPURM_EA_ABSW: ea_o = {{16{disp_i[15]}}, disp_i[15:0]};
         CPURM_EA_ABSL: ea_o = disp_i;
         CPURM_EA_IMM: ea_o = pc_i;
         default: ea_o = 32'h00000000;
      endcase
   end
endmodule : cpurm_ea_unit

// ===== tb/cpurm_regmodel_checker.sv
// Port assertions for the register model
`timescale 1ns/100ps
module cpurm_regmodel_checker (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   input wire logic [2:0] irq_level_i,
   input wire logic irq_accept_o,
   input wire logic [31:0] vector_addr_o,
   input wire logic trap_o,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   // Handshake and event relations
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("rvalid dropped early");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   AST_AW_BLOCK: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready))
      else $error("write response without a held write address");
   AST_IRQ_TOP: assert property (clk_en_i && irq_level_i == 3'h7 |=> irq_accept_o)
      else $error("level seven not accepted");
   AST_IRQ_NONE: assert property (clk_en_i && irq_level_i == 3'h0 |=> !irq_accept_o)
      else $error("level zero accepted");
   AST_TRAP_PULSE: assert property (trap_o |=> !trap_o)
      else $error("trap wider than one cycle");
   AST_VEC_CAUSE: assert property ($changed(vector_addr_o) |-> trap_o)
      else $error("vector moved without trap");
endmodule : cpurm_regmodel_checker

bind cpurm_regmodel cpurm_regmodel_checker u_chk (.core_clk_i(core_clk_i),
   .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .irq_level_i(irq_level_i),
   .irq_accept_o(irq_accept_o), .vector_addr_o(vector_addr_o), .trap_o(trap_o),
   .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ===== tb/cpu_programmer_register_model_tb.sv
// Register-level testbench for the register model
`timescale 1ns/100ps
module cpu_programmer_register_model_tb;
   logic core_clk, sys_rst, clk_en, awvalid, wvalid, arvalid, bready, rready;
   logic [2:0] irq_lvl;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   wire awready, wready, bvalid, arready, rvalid, irq_acc, trap;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata, vec;
   int err_total = 0, tests_run = 0, traps = 0;
   cpurm_regmodel dut (.core_clk_i(core_clk), .sys_rst_i(sys_rst), .clk_en_i(clk_en),
      .irq_level_i(irq_lvl), .irq_accept_o(irq_acc), .vector_addr_o(vec), .trap_o(trap),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   // Clock and trap pulse counter
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (trap === 1'b1) traps <= traps + 1;
   task report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Write: both channels offered, each released when taken
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      chk({30'h0, bresp}, {30'h0, er});
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      chk(rdata & m, e);
      chk({30'h0, rresp}, {30'h0, er});
   endtask : rd
   task irq(input logic [2:0] l, input logic e);
      irq_lvl <= l;
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq_acc}, {31'h0, e});
   endtask : irq
   // Watchdog
   initial begin
      repeat (5000) @(posedge core_clk);
      err_total++;
      report_and_stop;
   end
   // Main sequence
   initial begin
      {sys_rst, clk_en, bready, rready} = 4'hF;
      {awvalid, wvalid, arvalid, irq_lvl, awaddr, araddr, wdata, wstrb} = '0;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      rd(8'h08, 32'h0000FFFF, 32'h00002700, 2'h0);
      wr(8'h40, 32'hA5A55A5A, 4'hF, 2'h0);
      rd(8'h40, 32'hFFFFFFFF, 32'hA5A55A5A, 2'h0);
      wr(8'h60, 32'h000000FF, 4'h1, 2'h2);
      rd(8'h80, 32'hFFFFFFFF, 32'h0, 2'h2);
      wr(8'h14, 32'hFFFFFFFF, 4'hF, 2'h0);
      rd(8'h14, 32'hFFFFFFFF, 32'h00000007, 2'h0);
      wr(8'h20, 32'h1234ABCD, 4'hF, 2'h0);
      rd(8'h20, 32'hFFFFFFFF, 32'h1234ABCD, 2'h0);
      $display("test registers done");
      wr(8'h28, 32'h00000111, 4'hF, 2'h0);
      wr(8'h2C, 32'h00000222, 4'hF, 2'h0);
      wr(8'h24, 32'h00000333, 4'hF, 2'h0);
      rd(8'h7C, 32'hFFFFFFFF, 32'h00000111, 2'h0);
      wr(8'h08, 32'h00003700, 4'hF, 2'h0);
      rd(8'h7C, 32'hFFFFFFFF, 32'h00000222, 2'h0);
      $display("test stack select done");
      irq(3'h7, 1'b1);
      wr(8'h08, 32'h00002300, 4'hF, 2'h0);
      irq(3'h3, 1'b0);
      irq(3'h4, 1'b1);
      $display("test interrupt mask done");
      wr(8'h10, 32'h00001000, 4'hF, 2'h0);
      wr(8'h44, 32'h0000000A, 4'hF, 2'h0);
      wr(8'h1C, 32'h00000000, 4'hF, 2'h0);
      wr(8'h30, 32'h00000005, 4'hF, 2'h0);
      wr(8'h00, 32'h00000012, 4'hF, 2'h0);
      repeat (4) @(posedge core_clk);
      chk(traps, 32'h1);
      chk(vec, 32'h00001018);
      rd(8'h08, 32'h00000001, 32'h00000001, 2'h0);
      $display("test bound check done");
      wr(8'h08, 32'h0000A300, 4'hF, 2'h0);
      wr(8'h00, 32'h00400011, 4'hF, 2'h0);
      rd(8'h04, 32'h0000000F, 32'h00000009, 2'h0);
      chk(vec, 32'h00001024);
      rd(8'h44, 32'hFFFFFFFF, 32'h00000009, 2'h0);
      rd(8'h0C, 32'hFFFFFFFF, 32'h00000005, 2'h0);
      wr(8'h60, 32'h00000100, 4'hF, 2'h0);
      wr(8'h00, 32'h00206184, 4'hF, 2'h0);
      rd(8'h30, 32'hFFFFFFFF, 32'h00000129, 2'h0);
      wr(8'h00, 32'h00043084, 4'hF, 2'h0);
      rd(8'h60, 32'hFFFFFFFF, 32'h00000104, 2'h0);
      wr(8'h30, 32'hFFFFFFFC, 4'hF, 2'h0);
      wr(8'h08, 32'h00006300, 4'hF, 2'h0);
      wr(8'h00, 32'h00000016, 4'hF, 2'h0);
      rd(8'h08, 32'h0000001F, 32'h00000011, 2'h0);
      chk(traps, 32'h3);
      $display("test execute and trace done");
      wr(8'h08, 32'h00000000, 4'hF, 2'h0);
      rd(8'h7C, 32'hFFFFFFFF, 32'h00000333, 2'h0);
      wr(8'h08, 32'h00002700, 4'hF, 2'h0);
      @(posedge core_clk);
      rd(8'h08, 32'h0000FF00, 32'h0, 2'h0);
      chk(traps, 32'h4);
      chk(vec, 32'h00001020);
      rd(8'h04, 32'h00000002, 32'h00000002, 2'h0);
      $display("test user privilege done");
      clk_en <= 1'b0;
      irq(3'h0, 1'b1);
      clk_en <= 1'b1;
      irq(3'h0, 1'b0);
      $display("test clock enable done");
      report_and_stop;
   end
endmodule : cpu_programmer_register_model_tb
